// ### bench/low_power_wakeup_controller_tb_top.sv
// Self-checking bench of the low-power wake-up controller.
`timescale 1ns/1ps
module low_power_wakeup_controller_tb_top;
  import lpw_pkg::*;
  localparam int CEIL = 5000;
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, lvo = 1'b0, below = 1'b0;
  logic lf = 1'b0, temp_en = 1'b0, cur_ok = 1'b0, oocal = 1'b0;
  logic ahc_clr = 1'b0, tirq = 1'b0, lin_rx = 1'b1, lin_en = 1'b0;
  logic hv = 1'b0, pcfg = 1'b0, ltc = 1'b0;
  logic [15:0] trig_per = 16'h0000;
  logic [23:0] cur_res = 24'h000000;
  logic [7:0] current_threshold_value = 8'h00, thf = 8'h00;
  logic [30:0] ahth = 31'h7fffffff;
  logic [2:0] pb_en = 3'h0;
  logic [5:0] pb_sel = 6'h00;
  logic [3:0] toc = 4'h0;
  lpw_wake_en_t wake_en = '0;
  logic opm_wr, ten_clr, osc_gate, ctrig, ttrig, vchan, lintx, wake, timer_enable_bit;
  logic [1:0] opm_bits;
  lpw_flags_t flag_clr, flags;
  lpw_mode_t mode;
  logic [31:0] ahc;
  logic [7:0] filt;
  logic [2:0] pboc;
  int miscompares = 0, n_tests = 0, cycles = 0;
  int n_wake = 0, n_ctrig = 0, n_ttrig = 0, w0, c0, t0;

  lpw_wake_ctrl #(.LIN_FILT_CYC(4)) dut (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .opm_wr_in(opm_wr),
    .operating_mode_bits_in(opm_bits), .low_voltage_option_bit_in(lvo),
    .below_crank_level_in(below), .calibrated_low_freq_clock_in(lf),
    .cyclic_trigger_period_in(trig_per), .temp_meas_en_in(temp_en),
    .current_valid_in(cur_ok), .current_result_in(cur_res),
    .out_of_cal_in(oocal), .current_threshold_value_in(current_threshold_value),
    .threshold_filter_period_in(thf), .amp_hour_threshold_in(ahth),
    .accumulator_reset_ctl_in(ahc_clr), .wake_en_in(wake_en),
    .port_b_wake_en_in(pb_en), .port_b_oc_sel_in(pb_sel),
    .timer_oc_in(toc), .timer_irq_in(tirq), .timer_enable_clr_in(ten_clr),
    .lin_rx_in(lin_rx), .lin_module_enable_in(lin_en),
    .hv_wake_pin_in(hv), .port_wake_config_in(pcfg),
    .lifetime_overflow_in(ltc), .flag_clr_in(flag_clr), .mode_out(mode),
    .osc_gate_out(osc_gate), .current_trig_out(ctrig),
    .temp_trig_out(ttrig), .voltage_chan_en_out(vchan),
    .lin_tx_en_out(lintx), .wake_out(wake), .flags_out(flags),
    .amp_hour_accumulator_out(ahc), .filter_count_out(filt),
    .timer_enable_bit_out(timer_enable_bit), .port_b_oc_out(pboc)
  );
  lpw_mcu_model mcu (
    .ref_clk_in(ref_clk_in), .flags_in(flags), .opm_wr_out(opm_wr),
    .operating_mode_bits_out(opm_bits), .flag_clr_out(flag_clr),
    .timer_enable_clr_out(ten_clr)
  );

  initial
  begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Pulses are counted on the rising edge so the falling-edge stimulus
  // never reads a counter in the same time step as it moves.
  always @(posedge ref_clk_in)
  begin
    cycles++;
    n_wake += int'(wake === 1'b1);
    n_ctrig += int'(ctrig === 1'b1);
    n_ttrig += int'(ttrig === 1'b1);
    if (cycles == CEIL)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic go(input logic [1:0] code, input lpw_mode_t m);
    mcu.write_mode(code);
    check(32'(mode), 32'(m));
    check(32'(vchan), 32'(m == ST_NORMAL));
    check(32'(lintx), 32'(m == ST_NORMAL));
    if (m == ST_SLEEP || m == ST_STOP)
      check(32'(filt), 32'h0);
  endtask
  task automatic cur(input logic [23:0] v, input logic [7:0] f);
    @(negedge ref_clk_in);
    cur_res = v;
    cur_ok = 1'b1;
    @(negedge ref_clk_in);
    cur_ok = 1'b0;
    cur_res = ~v;
    check(32'(filt), 32'(f));
  endtask
  // Leaves the block in normal mode with its flags cleared.
  task automatic expect_wake(input lpw_flags_t f);
    int i;
    i = 0;
    while (wake !== 1'b1 && i < 60)
    begin
      @(negedge ref_clk_in);
      i++;
    end
    check(32'(wake), 32'h1);
    check(32'(flags), 32'(f));
    check(32'(mode), 32'(ST_INTER));
    wake_en = '0;
    mcu.clear_flags();
    mcu.write_mode(OPM_NORMAL);
    check(32'(flags), 32'h0);
  endtask

  initial
  begin
    repeat (12) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    @(negedge ref_clk_in);
    check(32'(vchan), 32'h1);
    check(32'(flags), 32'h0);
    cur(24'h000005, 8'h00);
    cur(24'hfffff8, 8'h00);
    check(ahc, 32'hfffffffd);
    cur(24'h800000, 8'h00);
    check(ahc, 32'hff7ffffd);
    @(negedge ref_clk_in);
    ahc_clr = 1'b1;
    @(negedge ref_clk_in);
    ahc_clr = 1'b0;
    check(ahc, 32'h0);
    current_threshold_value = 8'hff;
    ahth = 31'h00000003;
    wake_en.ahth = 1'b1;
    go(OPM_STOP, ST_STOP);
    w0 = n_wake;
    cur(24'h000002, 8'h00);
    repeat (3) @(negedge ref_clk_in);
    check(32'(n_wake - w0), 32'h0);
    cur(24'hfffffb, 8'h00);
    expect_wake(8'h21);
    check(ahc, 32'hfffffffd);
    ahth = 31'h7fffffff;
    // A plain compare against the unshifted threshold would count 1f up.
    current_threshold_value = 8'h10;
    thf = 8'h03;
    wake_en.current_threshold_value = 1'b1;
    go(OPM_SLEEP, ST_SLEEP);
    cur(24'h000020, 8'h01);
    cur(24'hffffe1, 8'h00);
    cur(24'hffffe0, 8'h01);
    cur(24'h00001f, 8'h00);
    cur(24'h000020, 8'h01);
    w0 = n_wake;
    cur(24'h000020, 8'h02);
    check(32'(n_wake - w0), 32'h0);
    cur(24'h000020, 8'h03);
    expect_wake(8'h41);
    wake_en.cal = 1'b1;
    go(OPM_SLEEP, ST_SLEEP);
    oocal = 1'b1;
    expect_wake(8'h11);
    oocal = 1'b0;
    wake_en.ltc = 1'b1;
    go(OPM_STOP, ST_STOP);
    @(negedge ref_clk_in);
    ltc = 1'b1;
    @(negedge ref_clk_in);
    ltc = 1'b0;
    expect_wake(8'h03);
    wake_en.hv = 1'b1;
    hv = 1'b1;
    go(OPM_SLEEP, ST_SLEEP);
    w0 = n_wake;
    repeat (8) @(negedge ref_clk_in);
    check(32'(n_wake - w0), 32'h0);
    pcfg = 1'b1;
    expect_wake(8'h05);
    hv = 1'b0;
    // The bus is dominant as low power is entered, in both module states.
    for (int en = 0; en < 2; en++)
    begin
      lin_en = en[0];
      lin_rx = 1'b0;
      // Let the dominant level pass the synchroniser before entry.
      repeat (3) @(negedge ref_clk_in);
      wake_en.lin = 1'b1;
      go(OPM_SLEEP, ST_SLEEP);
      w0 = n_wake;
      repeat (12) @(negedge ref_clk_in);
      lin_rx = 1'b1;
      if (en == 0)
      begin
        repeat (12) @(negedge ref_clk_in);
        check(32'(n_wake - w0), 32'h0);
        lin_rx = 1'b0;
        repeat (12) @(negedge ref_clk_in);
        lin_rx = 1'b1;
      end
      expect_wake(8'h09);
    end
    mcu.park_timer();
    check(32'(timer_enable_bit), 32'h0);
    trig_per = 16'h0003;
    temp_en = 1'b1;
    wake_en.timer = 1'b1;
    go(OPM_SLEEP, ST_SLEEP);
    c0 = n_ctrig;
    t0 = n_ttrig;
    w0 = n_wake;
    repeat (9)
    begin
      lf = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      lf = 1'b0;
      repeat (4) @(negedge ref_clk_in);
    end
    check(32'(n_ctrig - c0), 32'h3);
    check(32'(n_ttrig - t0), 32'h3);
    check(32'(n_wake - w0), 32'h0);
    check(32'(timer_enable_bit), 32'h1);
    pb_sel = 6'h02;
    pb_en = 3'h1;
    toc = 4'h4;
    expect_wake(8'h01);
    check(32'(pboc), 32'h1);
    toc = 4'h0;
    wake_en.timer = 1'b1;
    go(OPM_SLEEP, ST_SLEEP);
    tirq = 1'b1;
    expect_wake(8'h01);
    tirq = 1'b0;
    lvo = 1'b1;
    below = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    go(OPM_STOP, ST_CRANK);
    check(32'(osc_gate), 32'h1);
    below = 1'b0;
    expect_wake(8'h81);
    go(OPM_STOP, ST_STOP);
    below = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    check(32'(mode), 32'(ST_CRANK));
    below = 1'b0;
    expect_wake(8'h81);
    summarize();
  end
endmodule

// ### bench/lpw_mcu_model.sv
// Behavioural model of the controller die that commands the wake block.
`timescale 1ns/1ps
module lpw_mcu_model
(
  input wire logic ref_clk_in,
  input wire lpw_pkg::lpw_flags_t flags_in,
  output logic opm_wr_out,
  output logic [1:0] operating_mode_bits_out,
  output lpw_pkg::lpw_flags_t flag_clr_out,
  output logic timer_enable_clr_out
);
  import lpw_pkg::*;
  initial
  begin
    opm_wr_out = 1'b0;
    operating_mode_bits_out = 2'h3;
    flag_clr_out = FLAGS_RST;
    timer_enable_clr_out = 1'b0;
  end
  // The code turns wrong once the strobe drops, so a design that samples
  // the mode lines without the strobe is caught.
  task automatic write_mode(input logic [1:0] code);
    @(negedge ref_clk_in);
    opm_wr_out = 1'b1;
    operating_mode_bits_out = code;
    @(negedge ref_clk_in);
    opm_wr_out = 1'b0;
    operating_mode_bits_out = ~code;
  endtask
  task automatic clear_flags();
    @(negedge ref_clk_in);
    flag_clr_out = flags_in;
    @(negedge ref_clk_in);
    flag_clr_out = FLAGS_RST;
  endtask
  // The timer is set up with its enable cleared before low power.
  task automatic park_timer();
    @(negedge ref_clk_in);
    timer_enable_clr_out = 1'b1;
    @(negedge ref_clk_in);
    timer_enable_clr_out = 1'b0;
  endtask
endmodule

// ### rtl/lpw_lin_wake.sv
// Bus wake detector: long dominant level followed by a rising edge.
`timescale 1ns/1ps
module lpw_lin_wake #(
  parameter int unsigned FILT_CYC = lpw_pkg::LIN_FILT_CYC_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic lp_in,
  input wire logic lp_entry_in,
  input wire logic rx_in,
  input wire logic lin_module_enable_in,
  output logic wake_out
);
  import lpw_pkg::*;

  localparam logic [15:0] FILT = 16'(FILT_CYC);

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic entry_dom;
  logic next_entry_dom;
  logic rx_prev;
  logic next_wake;
  logic rise;

  // ----------------------------------------------------------------
  // Dominant timing and edge qualification
  // ----------------------------------------------------------------
  always_comb
  begin
    rise = rx_in & ~rx_prev;
    next_cnt = cnt;
    next_entry_dom = entry_dom;
    next_wake = 1'b0;
    // Entry is flagged while the low-power level is still low, so it
    // must be tested before the idle branch or the bus state is lost.
    if (lp_entry_in)
    begin
      next_cnt = 16'h0000;
      next_entry_dom = ~rx_in; // see R19
    end
    else if (!lp_in)
    begin
      next_cnt = 16'h0000;
      next_entry_dom = 1'b0;
    end
    else
    begin
      if (!rx_in && cnt != FILT)
        next_cnt = cnt + 16'h0001;
      else if (rx_in)
        next_cnt = 16'h0000;
      // A dominant bus at entry only wakes on release when enabled;
      // otherwise the release re-arms normal detection.
      if (rise)
      begin
        next_wake = entry_dom ? lin_module_enable_in
                              : (cnt == FILT); // see R18 see R19
        next_entry_dom = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt <= 16'h0000;
      entry_dom <= 1'b0;
      rx_prev <= 1'b1;
      wake_out <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      entry_dom <= next_entry_dom;
      rx_prev <= rx_in;
      wake_out <= next_wake;
    end
  end

  initial
  begin
    if (FILT_CYC < 1 || FILT_CYC > 65535)
      $error("FILT_CYC out of range");
  end

endmodule

// ### rtl/lpw_pkg.sv
// Shared constants and types of the low-power wake-up controller.
package lpw_pkg;

  // ----------------------------------------------------------------
  // Operating mode codes and controller states
  // ----------------------------------------------------------------
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] OPM_STOP = 2'h1;
  localparam logic [1:0] OPM_SLEEP = 2'h2;

  typedef enum logic [2:0]
  {
    ST_NORMAL = 3'b000,
    ST_STOP = 3'b001,
    ST_SLEEP = 3'b010,
    ST_CRANK = 3'b011,
    ST_INTER = 3'b100
  } lpw_mode_t;

  // ----------------------------------------------------------------
  // Flag and enable groups
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic uv;
    logic current_threshold_value;
    logic ahth;
    logic cal;
    logic lin;
    logic hv;
    logic ltc;
    logic general;
  } lpw_flags_t;

  typedef struct packed
  {
    logic current_threshold_value;
    logic ahth;
    logic cal;
    logic timer;
    logic lin;
    logic hv;
    logic ltc;
  } lpw_wake_en_t;

  // ----------------------------------------------------------------
  // Reset values, field layout and timing
  // ----------------------------------------------------------------
  localparam lpw_flags_t FLAGS_RST = 8'h00;
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [7:0] FILT_MAX = 8'hff;
  localparam logic [31:0] AHC_RST = 32'h0000_0000;
  localparam logic [15:0] TRIG_RST = 16'h0000;
  localparam int SYNC_LF = 0;
  localparam int SYNC_UV = 1;
  localparam int SYNC_LIN = 2;
  localparam int SYNC_HV = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LIN_FILT_NS = 100000;
  localparam int LIN_FILT_CYC_DEF =
    (LIN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ### rtl/lpw_wake_ctrl.sv
// Cranking mode and low-power wake-up source controller.
//
// Function
// R1: Enter cranking on low supply with option set; code enters it only from stop or on a stop command, never from sleep
// R2: Gate oscillator, stop acquisitions while cranking
// R3: Cranking exit wakes with undervoltage flag, intermediate
// R4: Low-frequency counter triggers cyclic current measurement
// R5: Measurement alone never wakes the controller
// R6: Compare absolute current with threshold shifted one
// R7: Filter counter counts up at/above, else down
// R8: Filter period reached and enabled: wake, flag
// R9: Filter counter cleared on each low-power entry
// R10: Add each signed result into 32-bit accumulator
// R11: Accumulator magnitude over threshold wakes when enabled
// R12: Reset control clears accumulator; always readable
// R13: Out-of-calibration temperature wakes when enabled
// R14: Timer compares routed to port bits wake
// R15: Timer wake enable sets timer enable after switch
// R16: Software configures timer with enable left cleared
// R17: Low power: current only, voltage channel idle; code also triggers temperature measurement when temp_meas_en_in is set
// R18: Long dominant then rising edge wakes
// R19: Dominant at entry wakes only if enabled
// R20: High wake pin wakes when both bits set
// R21: Lifetime counter overflow wakes when enabled
// R22: Any wake also sets general wake flag
// R23: Controller selects sleep with mode code two
`timescale 1ns/1ps
module lpw_wake_ctrl #(
  parameter int unsigned LIN_FILT_CYC = lpw_pkg::LIN_FILT_CYC_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic opm_wr_in,
  input wire logic [1:0] operating_mode_bits_in,
  input wire logic low_voltage_option_bit_in,
  input wire logic below_crank_level_in,
  input wire logic calibrated_low_freq_clock_in,
  input wire logic [15:0] cyclic_trigger_period_in,
  input wire logic temp_meas_en_in,
  input wire logic current_valid_in,
  input wire logic [23:0] current_result_in,
  input wire logic out_of_cal_in,
  input wire logic [7:0] current_threshold_value_in,
  input wire logic [7:0] threshold_filter_period_in,
  input wire logic [30:0] amp_hour_threshold_in,
  input wire logic accumulator_reset_ctl_in,
  input wire lpw_pkg::lpw_wake_en_t wake_en_in,
  input wire logic [2:0] port_b_wake_en_in,
  input wire logic [5:0] port_b_oc_sel_in,
  input wire logic [3:0] timer_oc_in,
  input wire logic timer_irq_in,
  input wire logic timer_enable_clr_in,
  input wire logic lin_rx_in,
  input wire logic lin_module_enable_in,
  input wire logic hv_wake_pin_in,
  input wire logic port_wake_config_in,
  input wire logic lifetime_overflow_in,
  input wire lpw_pkg::lpw_flags_t flag_clr_in,
  output lpw_pkg::lpw_mode_t mode_out,
  output logic osc_gate_out,
  output logic current_trig_out,
  output logic temp_trig_out,
  output logic voltage_chan_en_out,
  output logic lin_tx_en_out,
  output logic wake_out,
  output lpw_pkg::lpw_flags_t flags_out,
  output logic [31:0] amp_hour_accumulator_out,
  output logic [7:0] filter_count_out,
  output logic timer_enable_bit_out,
  output logic [2:0] port_b_oc_out
);
  import lpw_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic lf_prev;
  logic lf_rise;
  logic below;

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1 <= 4'h4;
      sync2 <= 4'h4;
      lf_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {hv_wake_pin_in, lin_rx_in, below_crank_level_in,
                calibrated_low_freq_clock_in};
      sync2 <= sync1;
      lf_prev <= sync2[SYNC_LF];
    end
  end

  assign lf_rise = sync2[SYNC_LF] & ~lf_prev;
  assign below = sync2[SYNC_UV];

  // ----------------------------------------------------------------
  // Operating mode state machine
  // ----------------------------------------------------------------
  lpw_mode_t mode;
  lpw_mode_t next_mode;
  logic lp;
  logic next_lp;
  logic lp_entry;
  logic crank_exit;
  logic crank_cond;
  logic any_wake;

  assign lp = (mode == ST_STOP) || (mode == ST_SLEEP);
  assign crank_cond = low_voltage_option_bit_in & below;

  always_comb
  begin
    next_mode = mode;
    crank_exit = 1'b0;
    case (mode)
      ST_NORMAL, ST_INTER:
      begin
        if (opm_wr_in)
        begin
          case (operating_mode_bits_in)
            OPM_NORMAL: next_mode = ST_NORMAL;
            OPM_STOP: next_mode = crank_cond ? ST_CRANK
                                             : ST_STOP; // see R1
            OPM_SLEEP: next_mode = ST_SLEEP; // see R23
            default: next_mode = mode;
          endcase
        end
      end
      ST_STOP:
      begin
        if (crank_cond)
          next_mode = ST_CRANK; // see R1
        else if (any_wake)
          next_mode = ST_INTER;
        else if (opm_wr_in && operating_mode_bits_in == OPM_NORMAL)
          next_mode = ST_NORMAL;
      end
      ST_SLEEP:
      begin
        if (any_wake)
          next_mode = ST_INTER;
      end
      ST_CRANK:
      begin
        if (!below)
        begin
          next_mode = ST_INTER; // see R3
          crank_exit = 1'b1;
        end
      end
      default: next_mode = ST_NORMAL;
    endcase
    next_lp = (next_mode == ST_STOP) || (next_mode == ST_SLEEP);
    lp_entry = next_lp & ~lp;
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      mode <= ST_NORMAL;
    else
      mode <= next_mode;
  end

  assign mode_out = mode;
  // Cranking freezes the oscillator; the trigger counter clears and the filter
  // holds, so nothing is half-measured across the dip.
  assign osc_gate_out = (mode == ST_CRANK); // see R2
  assign voltage_chan_en_out = (mode == ST_NORMAL); // see R17
  assign lin_tx_en_out = ~lp & (mode != ST_CRANK); // see R18

  // ----------------------------------------------------------------
  // Cyclic acquisition, filter, accumulator and timer
  // ----------------------------------------------------------------
  logic [15:0] trig_cnt;
  logic [15:0] next_trig_cnt;
  logic next_ctrig;
  logic next_ttrig;
  logic [7:0] filt;
  logic [7:0] next_filt;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [31:0] cur_ext;
  logic [23:0] abs_cur;
  logic [23:0] thr_cur;
  logic [31:0] abs_acc;
  logic cur_ge;
  logic timer_enable_bit;
  logic next_ten;
  logic [2:0] next_pb;

  always_comb
  begin
    next_trig_cnt = trig_cnt;
    next_ctrig = 1'b0;
    if (!lp)
      next_trig_cnt = TRIG_RST;
    else if (lf_rise)
    begin
      if (trig_cnt + 16'h0001 >= cyclic_trigger_period_in)
      begin
        next_trig_cnt = TRIG_RST;
        next_ctrig = 1'b1; // see R4 see R17
      end
      else
        next_trig_cnt = trig_cnt + 16'h0001;
    end
    next_ttrig = next_ctrig & temp_meas_en_in;

    cur_ext = {{8{current_result_in[23]}}, current_result_in};
    abs_cur = current_result_in[23] ? 24'(-current_result_in)
                                    : current_result_in;
    thr_cur = {15'h0000, current_threshold_value_in, 1'b0}; // see R6
    cur_ge = abs_cur >= thr_cur;
    next_filt = filt;
    if (lp_entry)
      next_filt = FILT_RST; // see R9
    else if (lp && current_valid_in)
    begin
      if (cur_ge && filt != FILT_MAX)
        next_filt = filt + 8'h01; // see R7
      else if (!cur_ge && filt != FILT_RST)
        next_filt = filt - 8'h01; // see R7
    end

    next_acc = acc;
    if (accumulator_reset_ctl_in)
      next_acc = AHC_RST; // see R12
    else if (current_valid_in)
      next_acc = acc + cur_ext; // see R10
    abs_acc = acc[31] ? (32'h0000_0000 - acc) : acc;

    // Software must have left the enable cleared; it is set only
    // after the low-frequency clock has been seen in low power.
    next_ten = timer_enable_clr_in ? 1'b0 : timer_enable_bit;
    if (lp && wake_en_in.timer && lf_rise)
      next_ten = 1'b1; // see R15 see R16
    for (int i = 0; i < 3; i++)
      next_pb[i] = timer_oc_in[port_b_oc_sel_in[2*i +: 2]]; // see R14
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      trig_cnt <= TRIG_RST;
      current_trig_out <= 1'b0;
      temp_trig_out <= 1'b0;
      filt <= FILT_RST;
      acc <= AHC_RST;
      timer_enable_bit <= 1'b0;
      port_b_oc_out <= 3'h0;
    end
    else
    begin
      trig_cnt <= next_trig_cnt;
      current_trig_out <= next_ctrig;
      temp_trig_out <= next_ttrig;
      filt <= next_filt;
      acc <= next_acc;
      timer_enable_bit <= next_ten;
      port_b_oc_out <= next_pb;
    end
  end

  assign filter_count_out = filt;
  assign amp_hour_accumulator_out = acc;
  assign timer_enable_bit_out = timer_enable_bit;

  // ----------------------------------------------------------------
  // Wake sources and flags
  // ----------------------------------------------------------------
  logic lin_wake;
  logic ev_cth;
  logic ev_ahth;
  logic ev_cal;
  logic ev_tmr;
  logic ev_lin;
  logic ev_hv;
  logic ev_ltc;
  logic wake_fire;
  lpw_flags_t flags;
  lpw_flags_t next_flags;
  logic next_wake;

  lpw_lin_wake #(
    .FILT_CYC(LIN_FILT_CYC)
  ) u_lin_wake (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .lp_in(lp),
    .lp_entry_in(lp_entry),
    .rx_in(sync2[SYNC_LIN]),
    .lin_module_enable_in(lin_module_enable_in),
    .wake_out(lin_wake)
  );

  always_comb
  begin
    // Only derived conditions wake; the trigger itself is not one.
    ev_cth = wake_en_in.current_threshold_value & (filt == threshold_filter_period_in);
    ev_ahth = wake_en_in.ahth & (abs_acc >= {1'b0, amp_hour_threshold_in});
    ev_cal = wake_en_in.cal & out_of_cal_in; // see R13
    ev_tmr = (|(port_b_oc_out & port_b_wake_en_in))
           | (wake_en_in.timer & timer_irq_in); // see R14 see R15
    ev_lin = wake_en_in.lin & lin_wake; // see R18
    ev_hv = wake_en_in.hv & port_wake_config_in
          & sync2[SYNC_HV]; // see R20
    ev_ltc = wake_en_in.ltc & lifetime_overflow_in; // see R21
    any_wake = lp & (ev_cth | ev_ahth | ev_cal | ev_tmr | ev_lin
                     | ev_hv | ev_ltc); // see R5
    wake_fire = any_wake & (mode == ST_SLEEP | ~crank_cond);
    next_wake = wake_fire | crank_exit;
    // Hardware set wins over a clear in the same cycle.
    next_flags = flags & ~flag_clr_in;
    if (wake_fire)
    begin
      next_flags.current_threshold_value = next_flags.current_threshold_value | ev_cth; // see R8
      next_flags.ahth = next_flags.ahth | ev_ahth; // see R11
      next_flags.cal = next_flags.cal | ev_cal;
      next_flags.lin = next_flags.lin | ev_lin;
      next_flags.hv = next_flags.hv | ev_hv;
      next_flags.ltc = next_flags.ltc | ev_ltc;
    end
    if (crank_exit)
      next_flags.uv = 1'b1; // see R3
    if (next_wake)
      next_flags.general = 1'b1; // see R22
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      flags <= FLAGS_RST;
      wake_out <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      wake_out <= next_wake;
    end
  end

  assign flags_out = flags;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_crank_release;
    mode == ST_CRANK && !below;
  endsequence

  sequence s_inter_woken;
    mode == ST_INTER && wake_out && flags_out.uv && flags_out.general;
  endsequence

  a_crank_entry: assert property (mode == ST_STOP && crank_cond |=> mode == ST_CRANK) else $error("no cranking entry"); // see R1
  a_crank_gate: assert property (mode == ST_CRANK |-> osc_gate_out ##1 !current_trig_out) else $error("acquisition ran in cranking"); // see R2
  a_crank_exit: assert property (s_crank_release |=> s_inter_woken) else $error("bad cranking exit"); // see R3
  a_inter_hold: assert property (mode == ST_INTER && !opm_wr_in |=> mode == ST_INTER) else $error("left intermediate unbidden"); // see R3
  a_trig_only: assert property (lp && !any_wake && !crank_cond |=> !wake_out) else $error("wake without source"); // see R5
  a_filt_clear: assert property (lp_entry |=> filter_count_out == 8'h00) else $error("filter not cleared"); // see R9
  a_filt_up: assert property (lp && current_valid_in && cur_ge && filt != 8'hff && !lp_entry |=> filt == $past(filt) + 8'h01) else $error("filter did not count"); // see R7
  a_cth_wake: assert property (mode == ST_SLEEP && wake_en_in.current_threshold_value && filt == threshold_filter_period_in |=> wake_out && flags_out.current_threshold_value && mode == ST_INTER) else $error("threshold wake missed"); // see R8
  a_acc_add: assert property (current_valid_in && !accumulator_reset_ctl_in |=> acc == $past(acc) + $past(cur_ext)) else $error("accumulator add wrong"); // see R10
  a_acc_clr: assert property (accumulator_reset_ctl_in |=> acc == 32'h0000_0000) else $error("accumulator not cleared"); // see R12
  a_gen_flag: assert property (wake_out |-> flags_out.general) else $error("general flag missing"); // see R22

  initial
  begin
    if (LIN_FILT_CYC < 1 || LIN_FILT_CYC > 65535)
      $error("LIN_FILT_CYC out of range");
  end

endmodule
